// ### fdcdh_top.sv
// Functional notes
// - drive precompensation shift during double density writes
// - fault input in rw mode, track zero in seek
// - write protect in rw mode, two sided in seek
// - shared output: fault reset or step pulses
// - shared output: low current or step direction
// - fault clear pulse precedes head load
// - select output high seek, low read write
// - chip select high ignores strobes and bus
// - status register readable anytime, host never writes
// - data register is a stack of bytes
// - select 0 read places status on bus
// - select 1 read outputs current data byte
// - select 1 write captures bus byte
// - step interval programmable 1 to 16 ms, 2 to 32 ms with mini mode
// - density output high double, low single
`timescale 1ns/1ps

// ==========================================================
// byte stack: first in first out, valid and ready both sides
// ==========================================================
module fdcdh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];      // storage words
    logic [AW-1:0]    wr_ptr;           // next slot to fill
    logic [AW-1:0]    rd_ptr;           // oldest word
    logic [AW:0]      count;            // words held
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : fdcdh_fifo

// ==========================================================
// drive side sequencer and host register port
// ==========================================================
module fdcdh_top
    import fdcdh_pkg::*;
#(
    parameter int MS_CYC = fdcdh_pkg::MS_CYC_DEFAULT, // cycles per ms
    parameter int DEPTH  = 32
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // host register port
    input  wire logic       cs_b,
    input  wire logic       rd_b,
    input  wire logic       wr_b,
    input  wire logic       register_select,
    input  wire logic [7:0] host_data_in,
    output logic [7:0]      host_data_out,
    output logic            host_data_oe,
    // command side: bytes written by the host
    output logic            cmd_valid,
    input  wire logic       cmd_ready,
    output logic [7:0]      cmd_data,
    // command side: result bytes for the host
    input  wire logic       res_valid,
    output logic            res_ready,
    input  wire logic [7:0] res_data,
    // command side: status and phase
    input  wire logic       host_dir,
    input  wire logic       exec_mode,
    input  wire logic       core_busy,
    // command side: drive requests
    input  wire logic       seek_start,
    input  wire logic       seek_dir,
    input  wire logic [7:0] seek_steps,
    input  wire logic       rw_start,
    input  wire logic       rw_end,
    input  wire logic [1:0] drive_req,
    input  wire logic [3:0] step_rate,
    input  wire logic       mini_mode,
    input  wire logic       dd_req,
    input  wire logic [1:0] precomp_req,
    input  wire logic       write_bit,
    input  wire logic       low_current_req,
    output logic            seq_idle,
    output logic            drive_fault,
    output logic            home_track,
    output logic            write_protect,
    output logic            two_sided,
    // drive pins
    input  wire logic       fault_or_home_track,
    input  wire logic       protect_or_two_sided,
    output logic [1:0]      drive_number_sel,
    output logic            serial_write_stream,
    output logic [1:0]      precomp_shift,
    output logic            head_load_out,
    output logic            fault_clear_or_step,
    output logic            low_current_or_direction,
    output logic            rw_seek_out,
    output logic            double_density_mode
);
    import fdcdh_pkg::*;

    // ======================================================
    // host strobe decode
    // ======================================================
    logic       rd_act;         // legal read in progress
    logic       wr_act;         // legal data write in progress
    logic       wr_q;           // write seen last cycle
    logic       rd_data_q;      // data read seen last cycle
    logic [7:0] wr_byte;        // byte latched during write
    logic [7:0] status;         // live status value
    logic       tx_ready;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_pop;
    logic       tx_push;
    logic [3:0] busy_bits;

    // chip select gates both strobes; both low is ignored
    assign rd_act = !cs_b && !rd_b && wr_b;
    // status is read only: write with select 0 never decodes
    assign wr_act = !cs_b && !wr_b && rd_b && register_select;
    // pop at the trailing edge so a long strobe reads once
    assign rx_pop  = rd_data_q && !(rd_act && register_select);
    // capture at trailing edge, data is stable there
    assign tx_push = wr_q && !wr_act;

    // status byte assembled from live block state
    always_comb begin
        status = 8'h00;
        status[ST_DRIVE_BUSY +: 4] = busy_bits;
        status[ST_CTRL_BUSY]       = core_busy || head_load_out;
        status[ST_EXEC_MODE]       = exec_mode;
        status[ST_DIO]             = host_dir;
        // ready means the stack can take or give a byte
        status[ST_RQM]             = host_dir ? rx_valid : tx_ready;
    end

    // strobe history and write byte latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q      <= 1'b0;
            rd_data_q <= 1'b0;
            wr_byte   <= BUS_RESET;
        end else begin
            wr_q      <= wr_act;
            rd_data_q <= rd_act && register_select;
            if (wr_act) begin
                wr_byte <= host_data_in;
            end
        end
    end

    // bus drive: registered, so it follows the strobe by a cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_out <= BUS_RESET;
            host_data_oe  <= 1'b0;
        end else begin
            host_data_oe <= rd_act;
            if (!register_select) begin
                host_data_out <= status;
            end else begin
                host_data_out <= rx_data;
            end
        end
    end

    // ======================================================
    // data register stacks, one per direction
    // ======================================================
    // a write into a full stack is dropped; the host saw rqm low
    fdcdh_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (tx_push),
        .in_ready  (tx_ready),
        .in_data   (wr_byte),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  (cmd_data)
    );

    fdcdh_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_data)
    );

    // ======================================================
    // drive sequencer
    // ======================================================
    fdcdh_state_e state;
    logic [31:0]  tmr;          // phase timer
    logic [7:0]   steps_left;   // step pulses still due
    logic [31:0]  gap_cyc;      // programmed step interval
    logic         fr_seen;      // fault pulse issued this command

    // interval is (rate + 1) ms, doubled for mini drives
    always_comb begin
        gap_cyc = (32'(step_rate) + 32'd1) * 32'(MS_CYC);
        if (mini_mode) begin
            gap_cyc = gap_cyc << 1;
        end
    end

    assign busy_bits = (state == FDCDH_IDLE || !rw_seek_out)
                     ? 4'h0 : (4'h1 << drive_number_sel);

    // state, timer and step count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= FDCDH_IDLE;
            tmr        <= '0;
            steps_left <= '0;
        end else begin
            tmr <= tmr + 32'd1;
            unique case (state)
                FDCDH_IDLE: begin
                    tmr <= '0;
                    // seek wins if both requests land together
                    if (seek_start) begin
                        state      <= FDCDH_SEEK_SETUP;
                        steps_left <= seek_steps;
                    end else if (rw_start) begin
                        state <= FDCDH_FAULT_CLR;
                    end
                end
                FDCDH_SEEK_SETUP: begin
                    // one interval lets direction settle before step
                    if (steps_left == 8'h00) begin
                        state <= FDCDH_IDLE;
                    end else if (tmr >= gap_cyc - 32'd1) begin
                        state <= FDCDH_STEP_HIGH;
                        tmr   <= '0;
                    end
                end
                FDCDH_STEP_HIGH: begin
                    if (tmr == 32'(STEP_HIGH_CYC - 1)) begin
                        state      <= FDCDH_STEP_GAP;
                        tmr        <= '0;
                        steps_left <= steps_left - 8'd1;
                    end
                end
                FDCDH_STEP_GAP: begin
                    // rest of the programmed interval after the pulse
                    if (tmr >= gap_cyc - 32'(STEP_HIGH_CYC + 1)) begin
                        tmr   <= '0;
                        state <= (steps_left == 8'h00)
                               ? FDCDH_IDLE : FDCDH_STEP_HIGH;
                    end
                end
                FDCDH_FAULT_CLR: begin
                    if (tmr == 32'(FAULT_CLR_CYC - 1)) begin
                        state <= FDCDH_RW_ACTIVE;
                    end
                end
                FDCDH_RW_ACTIVE: begin
                    if (rw_end) begin
                        state <= FDCDH_IDLE;
                    end
                end
                default: begin
                    state <= FDCDH_IDLE;
                end
            endcase
        end
    end

    // drive select latched only when idle, so it never moves mid job
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_number_sel <= 2'h0;
        end else if (state == FDCDH_IDLE && (seek_start || rw_start)) begin
            drive_number_sel <= drive_req;
        end
    end

    // mode select and multiplexed drive outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rw_seek_out              <= 1'b0;
            fault_clear_or_step      <= 1'b0;
            low_current_or_direction <= 1'b0;
            head_load_out            <= 1'b0;
        end else begin
            if (state == FDCDH_IDLE && seek_start) begin
                rw_seek_out <= 1'b1;
            end else if (state == FDCDH_IDLE && rw_start) begin
                rw_seek_out <= 1'b0;
            end
            // fault reset pulse or step pulse, by phase
            fault_clear_or_step <= (state == FDCDH_STEP_HIGH)
                                || (state == FDCDH_FAULT_CLR);
            if (state == FDCDH_IDLE && seek_start) begin
                low_current_or_direction <= seek_dir;
            end else if (!rw_seek_out) begin
                low_current_or_direction <= low_current_req;
            end
            head_load_out <= (state == FDCDH_RW_ACTIVE) && !rw_end;
        end
    end

    // density, precompensation and write stream
    // the write clock rate itself comes from outside the block
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            double_density_mode <= 1'b0;
            precomp_shift       <= PRECOMP_NRM;
            serial_write_stream <= 1'b0;
        end else begin
            double_density_mode <= dd_req;
            // shift only applies in double density
            precomp_shift <= dd_req ? precomp_req : PRECOMP_NRM;
            serial_write_stream <= write_bit;
        end
    end

    // shared inputs split by the current mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_fault   <= 1'b0;
            home_track    <= 1'b0;
            write_protect <= 1'b0;
            two_sided     <= 1'b0;
            seq_idle      <= 1'b1;
        end else begin
            drive_fault   <= fault_or_home_track && !rw_seek_out;
            home_track    <= fault_or_home_track && rw_seek_out;
            write_protect <= protect_or_two_sided && !rw_seek_out;
            two_sided     <= protect_or_two_sided && rw_seek_out;
            seq_idle      <= (state == FDCDH_IDLE);
        end
    end

    // helper: a fault pulse was seen since the command began
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fr_seen <= 1'b0;
        end else if (state == FDCDH_IDLE) begin
            fr_seen <= 1'b0;
        end else if (fault_clear_or_step && !rw_seek_out) begin
            fr_seen <= 1'b1;
        end
    end

    // ======================================================
    // assertions
    // ======================================================
    sequence s_legal_status_read;
        !cs_b && !rd_b && wr_b && !register_select;
    endsequence

    property p_cs_blocks;
        @(posedge clk) disable iff (!rst_b)
        cs_b |=> !host_data_oe;
    endproperty
    a_cs_blocks: assert property (p_cs_blocks)
        else $error("bus driven while chip select high");

    property p_both_strobes;
        @(posedge clk) disable iff (!rst_b)
        (!rd_b && !wr_b) |=> !host_data_oe;
    endproperty
    a_both_strobes: assert property (p_both_strobes)
        else $error("bus driven on illegal strobe pair");

    property p_status_read;
        @(posedge clk) disable iff (!rst_b)
        s_legal_status_read |=>
            host_data_oe && host_data_out == $past(status);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status not presented on read");

    property p_fault_mode;
        @(posedge clk) disable iff (!rst_b)
        (fault_or_home_track && !rw_seek_out) |=> drive_fault && !home_track;
    endproperty
    a_fault_mode: assert property (p_fault_mode)
        else $error("fault input misrouted");

    property p_fr_before_hdl;
        @(posedge clk) disable iff (!rst_b)
        $rose(head_load_out) |-> fr_seen && !rw_seek_out;
    endproperty
    a_fr_before_hdl: assert property (p_fr_before_hdl)
        else $error("head load without fault reset");

    property p_step_width;
        @(posedge clk) disable iff (!rst_b)
        ($rose(fault_clear_or_step) && rw_seek_out)
            |=> fault_clear_or_step [*7];
    endproperty
    a_step_width: assert property (p_step_width)
        else $error("step pulse too short");

    property p_unit_stable;
        @(posedge clk) disable iff (!rst_b)
        (state != FDCDH_IDLE && $past(state) != FDCDH_IDLE)
            |-> $stable(drive_number_sel);
    endproperty
    a_unit_stable: assert property (p_unit_stable)
        else $error("unit select moved during operation");

    property p_precomp_sd;
        @(posedge clk) disable iff (!rst_b)
        !double_density_mode |-> precomp_shift == PRECOMP_NRM;
    endproperty
    a_precomp_sd: assert property (p_precomp_sd)
        else $error("precompensation in single density");

    property p_seek_mode;
        @(posedge clk) disable iff (!rst_b)
        (state == FDCDH_IDLE && seek_start) |=> rw_seek_out;
    endproperty
    a_seek_mode: assert property (p_seek_mode)
        else $error("seek did not select seek mode");

endmodule : fdcdh_top

// ### fdcdh_pkg.sv
// ==========================================================
// shared constants for the drive and host port block
// ==========================================================
package fdcdh_pkg;

    // ======================================================
    // clock and timing
    // ======================================================
    localparam int CLK_PERIOD_NS  = 10;     // 100 mhz system clock
    localparam int STEP_HIGH_NS   = 6000;   // step pulse active time
    localparam int FAULT_CLR_NS   = 8000;   // fault reset active time
    localparam int STEP_RATE_MS   = 1;      // step interval unit
    // least times round up to whole cycles
    localparam int STEP_HIGH_CYC  =
        (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAULT_CLR_CYC  =
        (FAULT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_CYC_DEFAULT =
        STEP_RATE_MS * 1000000 / CLK_PERIOD_NS;

    // ======================================================
    // controller status field positions
    // ======================================================
    localparam int ST_DRIVE_BUSY  = 0;      // bits 3..0, one per drive
    localparam int ST_CTRL_BUSY   = 4;
    localparam int ST_EXEC_MODE   = 5;
    localparam int ST_DIO         = 6;
    localparam int ST_RQM         = 7;

    // ======================================================
    // reset values and encodings
    // ======================================================
    localparam logic [7:0] BUS_RESET   = 8'h00;
    localparam logic [1:0] PRECOMP_NRM = 2'h0;  // normal timing
    localparam logic [1:0] PRECOMP_ELY = 2'h1;  // shifted early
    localparam logic [1:0] PRECOMP_LTE = 2'h2;  // shifted late
    localparam logic [3:0] RATE_RESET  = 4'h0;

    // drive sequencer states
    typedef enum logic [2:0] {
        FDCDH_IDLE,
        FDCDH_SEEK_SETUP,
        FDCDH_STEP_HIGH,
        FDCDH_STEP_GAP,
        FDCDH_FAULT_CLR,
        FDCDH_RW_ACTIVE
    } fdcdh_state_e;

endpackage : fdcdh_pkg

// ### fdcdh_drive_model.sv
`timescale 1ns/1ps
// ==========================================
// drive model: muxed sense lines and pulses
// ==========================================
module fdcdh_drive_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // controller drive pins
    input  wire logic rw_seek_out,
    input  wire logic fault_clear_or_step,
    // conditions set by the bench
    input  wire logic fault_cond,
    input  wire logic home_cond,
    input  wire logic protect_cond,
    input  wire logic sided_cond,
    // sense lines back
    output logic      fault_or_home_track,
    output logic      protect_or_two_sided,
    // counts for the bench
    output int        step_count,
    output int        clear_count,
    output int        step_gap
);
    logic last; // previous pulse level
    int   gap;  // cycles since last step
    // meaning follows the mode line, as a real drive's mux
    assign fault_or_home_track  = rw_seek_out ? home_cond : fault_cond;
    assign protect_or_two_sided = rw_seek_out ? sided_cond : protect_cond;
    // rising edge is a step in seek, a fault clear otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last        <= 1'b0;
            gap         <= 0;
            step_count  <= 0;
            clear_count <= 0;
            step_gap    <= 0;
        end else begin
            last <= fault_clear_or_step;
            gap  <= gap + 1;
            if (fault_clear_or_step && !last) begin
                if (rw_seek_out) begin
                    step_count <= step_count + 1;
                    step_gap   <= gap + 1;
                    gap        <= 0;
                end else begin
                    clear_count <= clear_count + 1;
                end
            end
        end
    end
endmodule : fdcdh_drive_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import fdcdh_pkg::*;
    localparam int MSC = 700; // short ms unit
    logic clk, rst_b, cs_b, rd_b, wr_b, register_select, cmd_ready;
    logic res_valid, host_dir, exec_mode, core_busy, seek_start;
    logic seek_dir, rw_start, rw_end, mini_mode, dd_req, write_bit;
    logic low_current_req, fault_cond, home_cond, protect_cond;
    logic sided_cond, e;
    logic [7:0] host_data_in, res_data, seek_steps, o, host_data_out;
    logic [7:0] cmd_data;
    logic [1:0] drive_req, precomp_req, drive_number_sel, precomp_shift;
    logic [3:0] step_rate;
    logic host_data_oe, cmd_valid, res_ready, seq_idle, drive_fault;
    logic home_track, write_protect, two_sided, fault_or_home_track;
    logic protect_or_two_sided, serial_write_stream, head_load_out;
    logic fault_clear_or_step, low_current_or_direction, rw_seek_out;
    logic double_density_mode;
    int step_count, clear_count, step_gap, err_count, checks_done, n;
    logic [31:0] seed;
    logic [7:0]  q[$]; // expected stack contents
    fdcdh_top #(.MS_CYC(MSC), .DEPTH(32)) i_dut (.clk, .rst_b, .cs_b,
        .rd_b, .wr_b, .register_select, .host_data_in, .host_data_out,
        .host_data_oe, .cmd_valid, .cmd_ready, .cmd_data, .res_valid,
        .res_ready, .res_data, .host_dir, .exec_mode, .core_busy,
        .seek_start, .seek_dir, .seek_steps, .rw_start, .rw_end,
        .drive_req, .step_rate, .mini_mode, .dd_req, .precomp_req,
        .write_bit, .low_current_req, .seq_idle, .drive_fault,
        .home_track, .write_protect, .two_sided, .fault_or_home_track,
        .protect_or_two_sided, .drive_number_sel, .serial_write_stream,
        .precomp_shift, .head_load_out, .fault_clear_or_step,
        .low_current_or_direction, .rw_seek_out, .double_density_mode);
    fdcdh_drive_model i_drv (.clk, .rst_b, .rw_seek_out,
        .fault_clear_or_step, .fault_cond, .home_cond, .protect_cond,
        .sided_cond, .fault_or_home_track, .protect_or_two_sided,
        .step_count, .clear_count, .step_gap);
    // ==========================================
    // helpers
    // ==========================================
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // one host access; strobes held two edges, then released
    task automatic acc(input logic [3:0] p, input logic [7:0] d);
        cs_b <= p[3];
        rd_b <= p[2];
        wr_b <= p[1];
        register_select <= p[0];
        host_data_in <= d;
        @(posedge clk);
        @(negedge clk);
        o = host_data_out;
        e = host_data_oe;
        @(posedge clk);
        {cs_b, rd_b, wr_b} <= 3'h7;
        repeat (3) @(posedge clk);
    endtask : acc
    // expected status byte while idle
    function automatic logic [7:0] st();
        return {host_dir ? q.size() > 0 : q.size() < 32, host_dir, exec_mode,
                core_busy, 4'h0};
    endfunction : st
    // ==========================================
    // clock, timeout, sequence
    // ==========================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (++n == 60000) begin
        err_count++;
        give_verdict();
    end
    initial begin
        {rst_b, cmd_ready, res_valid, exec_mode, seek_start, rw_start} = 0;
        {rw_end, mini_mode, dd_req, write_bit, low_current_req} = 0;
        {fault_cond, home_cond, protect_cond, sided_cond, seek_dir} = 0;
        {host_data_in, res_data, seek_steps, drive_req, precomp_req} = 0;
        {cs_b, rd_b, wr_b, register_select, core_busy, host_dir} = 6'h3e;
        step_rate = 4'h0;
        seed = 48721;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({seq_idle, double_density_mode, host_data_oe}, 3'h4);
        // commands fill 32, extras and illegal strobes change nothing
        for (int i = 0; i < 34; i++) begin
            o = rnd();
            if (q.size() < 32) q.push_back(o);
            acc(4'h5, o);
            // cs high write, both strobes at either select, status write
            acc(4'(16'h410d >> (4 * (i % 4))), rnd());
            chk(e, 1'b0);
        end
        acc(4'hb, 8'h00);
        chk(e, 1'b0);
        acc(4'h2, 8'h00);
        chk(o, st());
        @(posedge clk);
        cmd_ready <= 1'b1;
        while (q.size() > 0) begin
            @(negedge clk);
            chk({cmd_valid, cmd_data}, {1'b1, q.pop_front()});
        end
        @(negedge clk);
        chk(cmd_valid, 1'b0);
        // result stack filled until refused, then read back
        host_dir <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            res_valid <= 1'b1;
            res_data <= rnd();
            @(negedge clk);
            if (res_ready === 1'b1) q.push_back(res_data);
        end
        @(posedge clk);
        res_valid <= 1'b0;
        chk({res_ready, 8'(q.size())}, 9'd32);
        acc(4'h2, 8'h00);
        chk(o, st());
        for (int i = 0; i < 32; i++) begin
            acc(4'h3, 8'h00);
            chk({e, o}, {1'b1, q.pop_front()});
        end
        // seek: three steps toward drive two, mini doubles interval
        {step_rate, mini_mode, seek_dir, home_cond, sided_cond} <= 8'h1f;
        {seek_steps, drive_req, seek_start} <= {8'd3, 2'd2, 1'b1};
        @(posedge clk);
        seek_start <= 1'b0;
        acc(4'h2, 8'h00);
        chk(o[3:0], 4'h4);
        chk({rw_seek_out, low_current_or_direction}, 2'h3);
        chk({home_track, two_sided}, 2'h3);
        while (seq_idle !== 1'b1) begin
            @(negedge clk);
            chk(drive_number_sel, 2'h2);
        end
        chk(step_count, 3);
        chk(step_gap, 4 * MSC);
        // read/write: fault clear, then head load, then pin passing
        {fault_cond, protect_cond, dd_req, low_current_req} <= 4'hf;
        {write_bit, drive_req, rw_start} <= 4'hb;
        @(posedge clk);
        rw_start <= 1'b0;
        while (head_load_out !== 1'b1) @(negedge clk);
        chk(clear_count, 1);
        chk({rw_seek_out, drive_fault, write_protect}, 3'h3);
        chk({low_current_or_direction, drive_number_sel}, 3'h5);
        chk({serial_write_stream, double_density_mode}, 2'h3);
        for (int p = 0; p < 3; p++) begin
            @(posedge clk);
            precomp_req <= p[1:0];
            repeat (3) @(negedge clk);
            chk(precomp_shift, p[1:0]);
        end
        @(posedge clk);
        rw_end <= 1'b1;
        @(posedge clk);
        rw_end <= 1'b0;
        repeat (3) @(negedge clk);
        chk(head_load_out, 1'b0);
        give_verdict();
    end
endmodule : testbench
